/* File: design/stpr_cfg.svh */
// stepper parameter decode / status bank: offsets, field positions, reset values
// assumes inclusion by bare name from the design files only
`ifndef STPR_CFG_SVH
`define STPR_CFG_SVH

// status register addresses as seen by the serial master
`define STPR_ADDR_LIVE   8'h04
`define STPR_ADDR_XBRG   8'h05
`define STPR_ADDR_YBRG   8'h06
`define STPR_ADDR_POS    8'h07

// common reset value of every status register and of the read holding word
`define STPR_RST_BYTE    8'h00

// shared field positions
`define STPR_BIT_PARITY  7
// live fault register
`define STPR_BIT_TWARN   6
`define STPR_BIT_PUMP    5
`define STPR_BIT_OPEN_COIL_X_FLAG   3
`define STPR_BIT_OPEN_COIL_Y_FLAG   2
// bridge registers: overcurrent nibble sits in bits 6..3 (pos top, pos bot, neg top, neg bot)
`define STPR_OC_MSB      6
`define STPR_OC_LSB      3
`define STPR_BIT_TSD     2

// step input polarity codes
`define STPR_EDGE_RISE   1'b0
`define STPR_EDGE_FALL   1'b1

// synchroniser depth
`define STPR_SYNC_STAGES 2

`endif

/* File: design/stpr_pkg.sv */
// types for the stepper parameter decode / status bank
// assumes stpr_cfg.svh supplies the numeric constants
package stpr_pkg;

  // decoded step resolution, in code order 000..111
  typedef enum logic [2:0] {
    STPR_MODE_32,
    STPR_MODE_16,
    STPR_MODE_8,
    STPR_MODE_4,
    STPR_MODE_HALF_UNC,
    STPR_MODE_HALF_CMP,
    STPR_MODE_FULL,
    STPR_MODE_RSVD
  } stpr_mode_t;

endpackage

/* File: design/stpr_sync.sv */
// multi-bit level synchroniser, one flop chain per bit
// assumes each bit is an independent level; words must not pass through here
`timescale 1ns/10ps
module stpr_sync
  import stpr_pkg::*;
#(
  parameter int W      = 1,
  parameter int STAGES = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);

  typedef struct packed {
    logic [STAGES-1:0][W-1:0] chain;
  } stpr_sync_st_t;

  stpr_sync_st_t st_ff;
  stpr_sync_st_t nxt_st;

  // fewer than two stages would let metastability reach the logic
  initial begin
    if (STAGES < 2 || W < 1) begin
      $error("stpr_sync: needs STAGES >= 2 and W >= 1");
    end
  end

  // shift: stage 0 is read only by stage 1
  always_comb begin
    nxt_st = st_ff;
    nxt_st.chain[0] = async;
    for (int i = 1; i < STAGES; i++) begin
      nxt_st.chain[i] = st_ff.chain[i-1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign synced = st_ff.chain[STAGES-1];

endmodule

/* File: design/stpr_param_status.sv */
// parameter decode, step edge detect, position count and four status registers
// assumes control fields come from the control register bank on clk_sys, fault
// conditions and the step pin are asynchronous, and reads arrive on the link clock
`timescale 1ns/10ps
`include "stpr_cfg.svh"

module stpr_param_status
  import stpr_pkg::*;
#(
  parameter int POS_W = 7
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             stepEdgeSelect,
  input  wire logic [4:0]       peakCurrentCode,
  input  wire logic [1:0]       slopeSelect,
  input  wire logic [2:0]       stepResolution,
  input  wire logic             stepDirNeg,
  input  wire logic             stepPulseInput,
  input  wire logic             thermalWarningFlag,
  input  wire logic             pumpFaultFlag,
  input  wire logic             openCoilXFlag,
  input  wire logic             openCoilYFlag,
  input  wire logic [3:0]       xBridgeOvercurrent,
  input  wire logic [3:0]       yBridgeOvercurrent,
  input  wire logic             thermalShutdownFlag,
  input  wire logic             linkClk,
  input  wire logic             linkRst,
  input  wire logic             linkRdReq,
  input  wire logic [7:0]       linkRdAddr,
  output logic      [9:0]       coilPeakCurrentMa,
  output logic      [7:0]       slopeVPerUs,
  output stpr_mode_t            stepMode,
  output logic                  microstepAdvance,
  output logic      [POS_W-1:0] microstepPosition,
  output logic      [7:0]       linkRdData,
  output logic                  linkRdDone
);

  // the status byte has exactly seven data bits below parity
  initial begin
    if (POS_W != 7) begin
      $error("stpr_param_status: POS_W must be 7");
    end
  end

  typedef struct packed {
    logic             stepPrev;
    logic [POS_W-1:0] pos;
    logic             advance;
    logic [9:0]       currentMa;
    logic [7:0]       slope;
    stpr_mode_t       mode;
    logic [3:0]       latX;
    logic [4:0]       latY;
    logic             reqSeen;
    logic             ackTgl;
    logic [7:0]       rdData;
  } stpr_sys_st_t;

  typedef struct packed {
    logic       reqTgl;
    logic [7:0] addr;
    logic       busy;
    logic       ackPrev;
    logic [7:0] data;
    logic       done;
  } stpr_link_st_t;

  stpr_sys_st_t  sys_ff;
  stpr_sys_st_t  nxt_sys;
  stpr_link_st_t lnk_ff;
  stpr_link_st_t nxt_lnk;

  logic [13:0] pinSync;
  logic        reqSyncd;
  logic        ackSyncd;

  // peak current table in mA, indexed by the five-bit code
  function automatic logic [9:0] currentOf(input logic [4:0] code);
    case (code)
      5'h00: currentOf = 10'h00F;  5'h01: currentOf = 10'h01E;
      5'h02: currentOf = 10'h02D;  5'h03: currentOf = 10'h032;
      5'h04: currentOf = 10'h037;  5'h05: currentOf = 10'h03D;
      5'h06: currentOf = 10'h043;  5'h07: currentOf = 10'h04A;
      5'h08: currentOf = 10'h052;  5'h09: currentOf = 10'h05B;
      5'h0A: currentOf = 10'h064;  5'h0B: currentOf = 10'h06E;
      5'h0C: currentOf = 10'h07A;  5'h0D: currentOf = 10'h087;
      5'h0E: currentOf = 10'h095;  5'h0F: currentOf = 10'h0A4;
      5'h10: currentOf = 10'h0B5;  5'h11: currentOf = 10'h0C8;
      5'h12: currentOf = 10'h0DD;  5'h13: currentOf = 10'h0F4;
      5'h14: currentOf = 10'h10D;  5'h15: currentOf = 10'h129;
      5'h16: currentOf = 10'h148;  5'h17: currentOf = 10'h16A;
      5'h18: currentOf = 10'h190;  5'h19: currentOf = 10'h1B9;
      5'h1A: currentOf = 10'h1E7;  5'h1B: currentOf = 10'h21A;
      5'h1C: currentOf = 10'h252;  5'h1D: currentOf = 10'h290;
      5'h1E: currentOf = 10'h2D4;  5'h1F: currentOf = 10'h320;
      default: currentOf = 10'h000;
    endcase
  endfunction

  // slope in V/us for the two-bit code
  function automatic logic [7:0] slopeOf(input logic [1:0] code);
    case (code)
      2'h0: slopeOf = 8'h96;
      2'h1: slopeOf = 8'h64;
      2'h2: slopeOf = 8'h32;
      2'h3: slopeOf = 8'h19;
      default: slopeOf = 8'h00;
    endcase
  endfunction

  // position increment per step edge; reserved mode does not move
  function automatic logic [POS_W-1:0] stepSizeOf(input stpr_mode_t m);
    case (m)
      STPR_MODE_32:       stepSizeOf = 7'h01;
      STPR_MODE_16:       stepSizeOf = 7'h02;
      STPR_MODE_8:        stepSizeOf = 7'h04;
      STPR_MODE_4:        stepSizeOf = 7'h08;
      STPR_MODE_HALF_UNC: stepSizeOf = 7'h10;
      STPR_MODE_HALF_CMP: stepSizeOf = 7'h10;
      STPR_MODE_FULL:     stepSizeOf = 7'h20;
      default:            stepSizeOf = 7'h00;
    endcase
  endfunction

  // even parity placed on top of seven data bits
  function automatic logic [7:0] withParity(input logic [6:0] d);
    withParity = {^d, d};
  endfunction

  // all asynchronous pins pass two flops before any use
  stpr_sync #(.W(14), .STAGES(`STPR_SYNC_STAGES)) u_pinSync (
    .clk    (clk_sys),
    .rst    (sys_rst),
    .async  ({stepPulseInput, thermalShutdownFlag, yBridgeOvercurrent,
              xBridgeOvercurrent, openCoilYFlag, openCoilXFlag, pumpFaultFlag,
              thermalWarningFlag}),
    .synced (pinSync)
  );

  // read request toggle into the system domain
  stpr_sync #(.W(1), .STAGES(`STPR_SYNC_STAGES)) u_reqSync (
    .clk    (clk_sys),
    .rst    (sys_rst),
    .async  (lnk_ff.reqTgl),
    .synced (reqSyncd)
  );

  // read acknowledge toggle back into the link domain
  stpr_sync #(.W(1), .STAGES(`STPR_SYNC_STAGES)) u_ackSync (
    .clk    (linkClk),
    .rst    (linkRst),
    .async  (sys_ff.ackTgl),
    .synced (ackSyncd)
  );

  // system domain: decode, stepping, latching, read service
  always_comb begin
    logic       stepNow;
    logic       stepWas;
    logic       edgeHit;
    logic [6:0] liveBits;
    logic [3:0] setX;
    logic [4:0] setY;
    logic       clrX;
    logic       clrY;
    stepNow  = pinSync[13];
    stepWas  = sys_ff.stepPrev;
    edgeHit  = 1'b0;
    liveBits = 7'h00;
    setX     = pinSync[7:4];
    setY     = {pinSync[11:8], pinSync[12]};
    clrX     = 1'b0;
    clrY     = 1'b0;
    nxt_sys  = sys_ff;
    nxt_sys.stepPrev = stepNow;
    if (stepEdgeSelect == `STPR_EDGE_RISE) begin
      edgeHit = stepNow & ~stepWas;
    end else begin
      edgeHit = ~stepNow & stepWas;
    end
    nxt_sys.currentMa = currentOf(peakCurrentCode);
    nxt_sys.slope = slopeOf(slopeSelect);
    nxt_sys.mode = stpr_mode_t'(stepResolution);
    // position counter, wraps over one electrical cycle
    nxt_sys.advance = edgeHit && (sys_ff.mode != STPR_MODE_RSVD);
    if (nxt_sys.advance) begin
      if (stepDirNeg) begin
        nxt_sys.pos = sys_ff.pos - stepSizeOf(sys_ff.mode);
      end else begin
        nxt_sys.pos = sys_ff.pos + stepSizeOf(sys_ff.mode);
      end
    end
    // live bits straight from synced conditions; pump level as is
    liveBits[`STPR_BIT_TWARN] = pinSync[0];
    liveBits[`STPR_BIT_PUMP]  = pinSync[1];
    liveBits[`STPR_BIT_OPEN_COIL_X_FLAG] = pinSync[2];
    liveBits[`STPR_BIT_OPEN_COIL_Y_FLAG] = pinSync[3];
    // read service: address word is stable while the request toggle is pending
    if (reqSyncd != sys_ff.reqSeen) begin
      nxt_sys.reqSeen = reqSyncd;
      nxt_sys.ackTgl  = ~sys_ff.ackTgl;
      // decode of the four addresses, others read zero
      case (lnk_ff.addr)
        `STPR_ADDR_LIVE: nxt_sys.rdData = withParity(liveBits);
        `STPR_ADDR_XBRG: begin
          nxt_sys.rdData = withParity({sys_ff.latX, 3'h0});
          clrX = 1'b1;
        end
        `STPR_ADDR_YBRG: begin
          nxt_sys.rdData = withParity({sys_ff.latY[4:1], sys_ff.latY[0], 2'h0});
          clrY = 1'b1;
        end
        `STPR_ADDR_POS:  nxt_sys.rdData = withParity(sys_ff.pos);
        default:         nxt_sys.rdData = `STPR_RST_BYTE;
      endcase
    end
    // X flags latch; read clears, a new event in the same cycle wins
    nxt_sys.latX = (clrX ? 4'h0 : sys_ff.latX) | setX;
    // Y flags and shutdown latch; same clear-on-read with set priority
    nxt_sys.latY = (clrY ? 5'h00 : sys_ff.latY) | setY;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sys_ff <= '0;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  // link domain: one outstanding read; requests while busy are dropped
  always_comb begin
    nxt_lnk = lnk_ff;
    nxt_lnk.done = 1'b0;
    if (!lnk_ff.busy && linkRdReq) begin
      nxt_lnk.addr   = linkRdAddr;
      nxt_lnk.reqTgl = ~lnk_ff.reqTgl;
      nxt_lnk.busy   = 1'b1;
    end else if (lnk_ff.busy && (ackSyncd != lnk_ff.ackPrev)) begin
      // system holding word is stable from the ack toggle until the next request
      nxt_lnk.ackPrev = ackSyncd;
      nxt_lnk.data    = sys_ff.rdData;
      nxt_lnk.done    = 1'b1;
      nxt_lnk.busy    = 1'b0;
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      lnk_ff <= '0;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  assign coilPeakCurrentMa = sys_ff.currentMa;
  assign slopeVPerUs       = sys_ff.slope;
  assign stepMode          = sys_ff.mode;
  assign microstepAdvance  = sys_ff.advance;
  assign microstepPosition = sys_ff.pos;
  assign linkRdData        = lnk_ff.data;
  assign linkRdDone        = lnk_ff.done;

endmodule

/* File: tb/stpr_param_status_checker.sv */
// port properties of the decode, step and status read logic
// assumes the bind at the foot attaches it to the bank
`timescale 1ns/10ps
module stpr_param_status_checker
  import stpr_pkg::*;
#(
  parameter int POS_W = 7
) (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       stepEdgeSelect,
  input wire logic [4:0] peakCurrentCode,
  input wire logic [1:0] slopeSelect,
  input wire logic [2:0] stepResolution,
  input wire logic       stepPulseInput,
  input wire logic       linkClk,
  input wire logic       linkRst,
  input wire logic       linkRdReq,
  input wire logic [9:0] coilPeakCurrentMa,
  input wire logic [7:0] slopeVPerUs,
  input wire stpr_mode_t stepMode,
  input wire logic       microstepAdvance,
  input wire logic [7:0] linkRdData,
  input wire logic       linkRdDone
);
  // mA per current code, V/us per slope code
  localparam logic [9:0] CUR [32] = '{10'h00F, 10'h01E, 10'h02D, 10'h032, 10'h037, 10'h03D,
    10'h043, 10'h04A, 10'h052, 10'h05B, 10'h064, 10'h06E, 10'h07A, 10'h087, 10'h095, 10'h0A4,
    10'h0B5, 10'h0C8, 10'h0DD, 10'h0F4, 10'h10D, 10'h129, 10'h148, 10'h16A, 10'h190, 10'h1B9,
    10'h1E7, 10'h21A, 10'h252, 10'h290, 10'h2D4, 10'h320};
  localparam logic [7:0] SLP [4] = '{8'h96, 8'h64, 8'h32, 8'h19};

  a_cur_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> coilPeakCurrentMa == CUR[$past(peakCurrentCode)]) else $error("bad mA");
  a_slope_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> slopeVPerUs == SLP[$past(slopeSelect)]) else $error("bad slope");
  a_mode_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> stepMode == stpr_mode_t'($past(stepResolution))) else $error("bad mode");
  // reserved mode idle; the pulse is judged by the mode that stood when it was made
  a_rsvd_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(stepMode) == STPR_MODE_RSVD |-> !microstepAdvance) else $error("step in reserved mode");
  // selected edge steps; the synchroniser sets the window
  a_edge_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (stepEdgeSelect ? $fell(stepPulseInput) : $rose(stepPulseInput)) && stepMode !=
    STPR_MODE_RSVD |-> ##[1:4] microstepAdvance) else $error("edge gave no step");
  a_rd_answer: assert property (@(posedge linkClk) disable iff (linkRst)
    linkRdReq |-> ##[3:13] linkRdDone) else $error("read not answered");
  a_even_par: assert property (@(posedge linkClk) disable iff (linkRst)
    linkRdDone |-> !(^linkRdData)) else $error("odd parity");
  a_data_hold: assert property (@(posedge linkClk) disable iff (linkRst)
    !linkRdDone && !$past(linkRst) |-> $stable(linkRdData)) else $error("data moved");

  c_step: cover property (@(posedge clk_sys) microstepAdvance);
  c_read: cover property (@(posedge linkClk) linkRdDone && linkRdData != 8'h00);
  c_top_cur: cover property (@(posedge clk_sys) peakCurrentCode == 5'h1F);
endmodule

bind stpr_param_status stpr_param_status_checker #(.POS_W(POS_W))
  stpr_param_status_checker_inst (.clk_sys, .sys_rst, .stepEdgeSelect, .peakCurrentCode,
  .slopeSelect, .stepResolution, .stepPulseInput, .linkClk, .linkRst, .linkRdReq,
  .coilPeakCurrentMa, .slopeVPerUs, .stepMode, .microstepAdvance, .linkRdData, .linkRdDone);

/* File: tb/stpr_link_master.sv */
// link-side reader in place of the serial master
// assumes the bench notes expected bytes itself before each read
`timescale 1ns/10ps
module stpr_link_master (
  input  wire logic       linkClk,
  input  wire logic       linkRdDone,
  output logic            linkRdReq,
  output logic      [7:0] linkRdAddr
);
  initial begin
    linkRdReq = 1'b0;
    linkRdAddr = 8'h00;
  end
  // one read at a time; idle address is scrambled so a stale one never matches
  task automatic rd(input logic [7:0] a, output bit late);
    int n;
    n = 0;
    @(posedge linkClk);
    linkRdReq <= 1'b1;
    linkRdAddr <= a;
    @(posedge linkClk);
    linkRdReq <= 1'b0;
    linkRdAddr <= ~a;
    do @(posedge linkClk); while (linkRdDone !== 1'b1 && ++n < 20);
    // a read that never completes is reported to the caller as late
    late = (n >= 20);
  endtask
endmodule

/* File: tb/stpr_param_status_test.sv */
// bench: decode sweep, stepping, live and latched status reads
// assumes the bound checker covers decode timing
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module stpr_param_status_test
  import stpr_pkg::*;
();
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       linkClk = 1'b0;
  logic       linkRst = 1'b1;
  logic       stepEdgeSelect, stepDirNeg, stepPulseInput, linkRdReq, linkRdDone;
  logic       thermalWarningFlag, pumpFaultFlag, openCoilXFlag, openCoilYFlag;
  logic       thermalShutdownFlag, microstepAdvance;
  logic [4:0] peakCurrentCode;
  logic [1:0] slopeSelect;
  logic [2:0] stepResolution;
  logic [3:0] xBridgeOvercurrent, yBridgeOvercurrent, f;
  logic [7:0] linkRdAddr, linkRdData, slopeVPerUs, rq[$];
  logic [9:0] coilPeakCurrentMa;
  logic [6:0] microstepPosition, pos, pq[$];
  logic [7:0] rqHead;
  logic [6:0] pqHead;
  stpr_mode_t stepMode;
  int         num_errors = 0;
  int         compares = 0;
  int         seed = 32'h5EC6;

  stpr_param_status #(.POS_W(7)) stpr_param_status_inst (.clk_sys, .sys_rst, .stepEdgeSelect,
    .peakCurrentCode, .slopeSelect, .stepResolution, .stepDirNeg, .stepPulseInput,
    .thermalWarningFlag, .pumpFaultFlag, .openCoilXFlag, .openCoilYFlag, .xBridgeOvercurrent,
    .yBridgeOvercurrent, .thermalShutdownFlag, .linkClk, .linkRst, .linkRdReq, .linkRdAddr,
    .coilPeakCurrentMa, .slopeVPerUs, .stepMode, .microstepAdvance, .microstepPosition,
    .linkRdData, .linkRdDone);
  stpr_link_master stpr_link_master_inst (.linkClk, .linkRdDone, .linkRdReq, .linkRdAddr);

  // rising edges of the two clocks never coincide
  always #50 clk_sys = ~clk_sys;
  always #15 linkClk = ~linkClk;

  // each answer is matched against the oldest note; popped once, since the macro
  // names its arguments twice, and an empty queue yields X so a surplus answer fails
  always @(posedge linkClk) if (linkRdDone === 1'b1) begin
    rqHead = 8'hXX;
    if (rq.size() > 0) rqHead = rq.pop_front();
    `CHK(linkRdData, rqHead)
  end
  always @(posedge clk_sys) if (microstepAdvance === 1'b1) begin
    pqHead = 7'hXX;
    if (pq.size() > 0) pqHead = pq.pop_front();
    `CHK(microstepPosition, pqHead)
  end

  function automatic logic [7:0] par(input logic [6:0] b);
    return {^b, b};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bit late;
    rq.push_back(e);
    stpr_link_master_inst.rd(a, late);
    // a read that ran out of time counts as a mismatch
    if (late) num_errors++;
  endtask
  // one selected edge, then the opposite one which must not step
  task automatic step(input logic [2:0] m, input logic sel, input logic dn);
    logic [6:0] sz;
    sz = (m == 3'h6) ? 7'h20 : (m > 3'h3) ? 7'h10 : 7'h01 << m;
    stepResolution <= m;
    stepEdgeSelect <= sel;
    stepDirNeg <= dn;
    stepPulseInput <= sel;
    tick(6);
    if (m != 3'h7) begin
      pos = dn ? pos - sz : pos + sz;
      pq.push_back(pos);
    end
    stepPulseInput <= ~sel;
    tick(4);
    stepPulseInput <= sel;
    tick(6);
  endtask
  task automatic results;
    if (rq.size() != 0 || pq.size() != 0) num_errors++;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // the tests need about 500 cycles; a hang ends the run
  initial begin
    tick(3000);
    num_errors++;
    results;
  end

  initial begin
    {stepEdgeSelect, stepDirNeg, stepPulseInput, thermalWarningFlag, pumpFaultFlag} = '0;
    {openCoilXFlag, openCoilYFlag, thermalShutdownFlag, xBridgeOvercurrent} = '0;
    {yBridgeOvercurrent, peakCurrentCode, slopeSelect, stepResolution} = '0;
    pos = 7'h00;
    tick(4);
    sys_rst <= 1'b0;
    @(posedge linkClk) linkRst <= 1'b0;
    // reset values, control and unmapped places read zero
    for (int a = 3; a < 9; a++) rd(8'(a), 8'h00);
    $display("test reset done");
    // every current code once, each slope and mode code several times; the bound properties judge the outputs
    for (int c = 0; c < 32; c++) begin
      peakCurrentCode <= 5'(c);
      slopeSelect <= 2'(c);
      stepResolution <= 3'(c);
      tick(2);
    end
    $display("test decode done");
    for (int m = 0; m < 16; m++) step(3'(m), m[3], 1'($random(seed)));
    rd(8'h07, par(pos));
    $display("test step done");
    // live flags follow the pins and are not held
    repeat (4) begin
      f = 4'($random(seed));
      {thermalWarningFlag, pumpFaultFlag, openCoilXFlag, openCoilYFlag} <= f;
      tick(5);
      rd(8'h04, par({f[3:2], 1'b0, f[1:0], 2'b00}));
    end
    {thermalWarningFlag, pumpFaultFlag, openCoilXFlag, openCoilYFlag} <= 4'h0;
    tick(5);
    rd(8'h04, 8'h00);
    $display("test live done");
    // a short fault stays held until its register is read
    f = 4'($random(seed)) | 4'h1;
    xBridgeOvercurrent <= f;
    yBridgeOvercurrent <= ~f;
    thermalShutdownFlag <= 1'b1;
    tick(3);
    {xBridgeOvercurrent, yBridgeOvercurrent, thermalShutdownFlag} <= '0;
    tick(5);
    rd(8'h08, 8'h00);
    rd(8'h05, par({f, 3'b000}));
    rd(8'h06, par({~f, 3'b100}));
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    $display("test latch done");
    tick(10);
    results;
  end
endmodule
